// *** hdl/pp_cfg.svh ***
// Constants for the parallel-poll configuration engine
`ifndef PP_CFG_SVH
`define PP_CFG_SVH
`define PP_UNL        8'h3F
`define PP_PPC        8'h05
`define PP_PPU        8'h15
`define PP_PPE_BASE   8'h60
`define PP_PPD_BYTE   8'h70
`define PP_LISTEN_OFS 8'h20
`define PP_TALK_OFS   8'h40
`define PP_LOCAL_ADDR 8'hFF
`define PP_U_BIT      4
`define PP_S_BIT      3
`define PP_OWN_ADDR   5'h00
`endif

// *** hdl/pp_engine.sv ***
// Parallel-poll command engine with own response logic
//
// What this block does
// - Configure sends own talk, unlisten, target listen, configure, enable.
// - Enable byte holds requested line and sense bit.
// - Enable byte always has U bit cleared.
// - Line 4 sense 0 gives 63; line 3 sense 1 gives 6A.
// - Several triples yield one full sequence each in turn.
// - Unconfigure sends talk, unlisten, target listen, configure, disable.
// - Unconfigure with no address sends universal unconfigure.
// - Address 255 configures own response locally, nothing on the bus.
// - Local request without local option: unchanged, capability error.
// - Poll returns byte with bit n-1 set for each asserted line n.
// - Shared line bit is OR of all responders.
// - In bus-host mode ist follows service request.
// - Own line asserted during poll only when ist equals sense.
// - Option clear: remote only; option set: local only outside bus-host mode.
// - Low three bits n select line n+1; bit 3 is sense.
// - Any byte 70 to 7F disables own response.
// - Bus-host mode accepts only remote configuration.
`timescale 1ns/1ps
`include "pp_cfg.svh"
module pp_engine
   import pp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       req_valid,
   input  wire req_t       req,
   output logic            req_ready,
   output logic            done,
   output logic [7:0]      poll_result,
   output logic            capability_error,
   output logic            not_controller_error,
   input  wire logic       local_option,
   input  wire logic       bus_host_mode,
   input  wire logic       controller_in_charge,
   input  wire logic       service_request_enable_function,
   output logic            srq_out,
   output logic            cmd_valid,
   output logic [7:0]      cmd_byte,
   input  wire logic       cmd_ready,
   output logic            poll_active,
   input  wire logic [7:0] dio_in,
   output logic [7:0]      dio_out,
   output logic            dio_oe,
   input  wire logic       rx_cmd_valid,
   input  wire logic [7:0] rx_cmd_byte,
   input  wire logic       device_ist,
   output logic            ist_out
);
   typedef enum logic [2:0] {
      S_IDLE,
      S_SEND,
      S_POLL,
      S_DONE
   } state_t;

   state_t     state_reg,  state_next;
   logic [2:0] step_reg,   step_next;
   logic [2:0] last_reg,   last_next;
   req_t       cur_reg,    cur_next;
   logic [7:0] cmd_reg,    cmd_next;
   logic       cv_reg,     cv_next;
   logic [7:0] res_reg,    res_next;
   logic       done_reg,   done_next;
   logic       capability_error_reg,   capability_error_next;
   logic       ecic_reg,   ecic_next;
   logic       srq_reg,    srq_next;
   logic       ist_reg,    ist_next;
   logic       pa_reg,     pa_next;
   logic [7:0] dout_reg,   dout_next;
   logic       doe_reg,    doe_next;
   logic       rdy_reg,    rdy_next;

   logic       lwr;
   ppcfg_t     lcfg;
   ppcfg_t     cfg;
   logic [7:0] own_resp;
   logic       ist_now;
   logic       remote_ok;
   logic       rx_ppe;
   logic [7:0] seq_byte;
   logic       local_req;
   logic [7:0] poll_bits;

   // Individual status follows the service request in bus-host mode
   assign ist_now = bus_host_mode ? srq_reg : device_ist;
   // Remote setting refused when local option set, but always in bus-host
   assign remote_ok = bus_host_mode || !local_option;
   assign rx_ppe = rx_cmd_valid &&
      ((rx_cmd_byte & 8'hE0) == `PP_PPE_BASE);
   // Address 255 on configure or unconfigure asks for own setup
   assign local_req = req.op != OP_POLL && !req.no_addr &&
      req.addr == `PP_LOCAL_ADDR;

   // Per-line poll sample: bus lines ORed with own response
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_line
         assign poll_bits[gi] = dio_in[gi] | own_resp[gi];
      end
   endgenerate

   // Stored own setting and response decode
   pp_response pp_response_inst (
      .clk            (clk),
      .resetn         (resetn),
      .local_wr       (lwr),
      .local_cfg      (lcfg),
      .remote_wr      (rx_ppe),
      .remote_byte    (rx_cmd_byte),
      .remote_allowed (remote_ok),
      .ist            (ist_now),
      .cfg            (cfg),
      .resp           (own_resp)
   );

   // Byte for the step after the current one of a sequence
   always_comb begin
      unique case (3'(step_reg + 3'd1))
         3'd0: seq_byte = `PP_TALK_OFS | {3'b000, `PP_OWN_ADDR};
         3'd1: seq_byte = `PP_UNL;
         3'd2: seq_byte = `PP_LISTEN_OFS | {3'b000, cur_reg.addr[4:0]};
         3'd3: seq_byte = `PP_PPC;
         default: begin
            if (cur_reg.op == OP_CONFIGURE) begin
               // Line n+1 carried as n, sense in S, U cleared
               seq_byte = `PP_PPE_BASE |
                  {4'h0, cur_reg.sense, 3'(cur_reg.line - 3'd1)};
            end else begin
               seq_byte = `PP_PPD_BYTE;
            end
         end
      endcase
   end

   // Local configure request decode
   always_comb begin
      lwr  = 1'b0;
      lcfg = cfg;
      if (state_reg == S_IDLE && req_valid && local_req &&
          local_option && !bus_host_mode) begin
         lwr          = 1'b1;
         lcfg.enabled = (req.op == OP_CONFIGURE);
         lcfg.sense   = req.sense;
         lcfg.line    = 3'(req.line - 3'd1);
      end
   end

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      step_next  = step_reg;
      last_next  = last_reg;
      cur_next   = cur_reg;
      cmd_next   = cmd_reg;
      cv_next    = cv_reg;
      done_next  = 1'b0;
      capability_error_next  = capability_error_reg;
      ecic_next  = ecic_reg;
      pa_next    = 1'b0;

      unique case (state_reg)
         S_IDLE: begin
            if (req_valid) begin
               cur_next  = req;
               capability_error_next = 1'b0;
               ecic_next = 1'b0;
               step_next = 3'd0;
               if (local_req) begin
                  capability_error_next  = !(local_option && !bus_host_mode);
                  state_next = S_DONE;
               end else if (!controller_in_charge) begin
                  ecic_next  = 1'b1;
                  state_next = S_DONE;
               end else if (req.op == OP_POLL) begin
                  state_next = S_POLL;
               end else if (req.no_addr) begin
                  // Universal unconfigure only
                  step_next  = 3'd4;
                  last_next  = 3'd4;
                  cmd_next   = `PP_PPU;
                  cv_next    = 1'b1;
                  state_next = S_SEND;
               end else begin
                  last_next  = 3'd4;
                  cmd_next   = `PP_TALK_OFS | {3'b000, `PP_OWN_ADDR};
                  cv_next    = 1'b1;
                  state_next = S_SEND;
               end
            end
         end

         S_SEND: begin
            if (cmd_ready) begin
               if (step_reg == last_reg) begin
                  cv_next    = 1'b0;
                  state_next = S_DONE;
               end else begin
                  step_next = 3'(step_reg + 3'd1);
               end
            end
         end

         // Two poll cycles, result taken on the second
         S_POLL: begin
            pa_next    = 1'b1;
            state_next = pa_reg ? S_DONE : S_POLL;
         end

         S_DONE: begin
            done_next  = 1'b1;
            state_next = S_IDLE;
         end
         default: state_next = S_IDLE;
      endcase
      // Load the next byte once the current one is taken
      if (state_reg == S_SEND && cmd_ready && step_reg != last_reg) begin
         cmd_next = seq_byte;
      end
      // Ready stands as a flop, high in idle
      rdy_next = (state_next == S_IDLE);
   end

   // Register all sequencer state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= S_IDLE;
         step_reg  <= 3'd0;
         last_reg  <= 3'd0;
         cur_reg   <= '0;
         cmd_reg   <= 8'h00;
         cv_reg    <= 1'b0;
         done_reg  <= 1'b0;
         capability_error_reg  <= 1'b0;
         ecic_reg  <= 1'b0;
         pa_reg    <= 1'b0;
         rdy_reg   <= 1'b1;
      end else begin
         state_reg <= state_next;
         step_reg  <= step_next;
         last_reg  <= last_next;
         cur_reg   <= cur_next;
         cmd_reg   <= cmd_next;
         cv_reg    <= cv_next;
         done_reg  <= done_next;
         capability_error_reg  <= capability_error_next;
         ecic_reg  <= ecic_next;
         pa_reg    <= pa_next;
         rdy_reg   <= rdy_next;
      end
   end

   // Status, own line drive and poll result next values
   always_comb begin
      srq_next  = service_request_enable_function && bus_host_mode;
      ist_next  = ist_now;
      // Own line driven outside own polls while enabled
      dout_next = own_resp;
      doe_next  = (own_resp != 8'h00) && !rx_cmd_valid && !pa_reg &&
                  cfg.enabled;
      // Poll byte sampled on each poll cycle
      res_next  = res_reg;
      if (state_reg == S_POLL) begin
         res_next = poll_bits;
      end
   end

   // Register status, own line drive and poll result
   always_ff @(posedge clk) begin
      if (!resetn) begin
         srq_reg   <= 1'b0;
         ist_reg   <= 1'b0;
         dout_reg  <= 8'h00;
         doe_reg   <= 1'b0;
         res_reg   <= 8'h00;
      end else begin
         srq_reg   <= srq_next;
         ist_reg   <= ist_next;
         dout_reg  <= dout_next;
         doe_reg   <= doe_next;
         res_reg   <= res_next;
      end
   end

   assign req_ready            = rdy_reg;
   assign done                 = done_reg;
   assign poll_result          = res_reg;
   assign capability_error     = capability_error_reg;
   assign not_controller_error = ecic_reg;
   assign srq_out              = srq_reg;
   assign cmd_valid            = cv_reg;
   assign cmd_byte             = cmd_reg;
   assign poll_active          = pa_reg;
   assign dio_out              = dout_reg;
   assign dio_oe               = doe_reg;
   assign ist_out              = ist_reg;
endmodule : pp_engine

// *** hdl/pp_pkg.sv ***
// Types for the parallel-poll configuration engine
package pp_pkg;
   typedef enum logic [1:0] {
      OP_CONFIGURE,
      OP_UNCONFIGURE,
      OP_POLL
   } op_t;

   // One request from the serial command side
   typedef struct packed {
      op_t        op;
      logic [7:0] addr;
      logic [2:0] line;
      logic       sense;
      logic       no_addr;
   } req_t;

   // Stored poll response setting
   typedef struct packed {
      logic       enabled;
      logic       sense;
      logic [2:0] line;
   } ppcfg_t;
endpackage : pp_pkg

// *** hdl/pp_response.sv ***
// Own parallel-poll response and stored poll setting
`timescale 1ns/1ps
`include "pp_cfg.svh"
module pp_response
   import pp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       local_wr,
   input  wire ppcfg_t     local_cfg,
   input  wire logic       remote_wr,
   input  wire logic [7:0] remote_byte,
   input  wire logic       remote_allowed,
   input  wire logic       ist,
   output ppcfg_t          cfg,
   output logic [7:0]      resp
);
   ppcfg_t cfg_reg;
   ppcfg_t cfg_next;

   // Next setting from local or remote configuration
   always_comb begin
      cfg_next = cfg_reg;
      if (local_wr) begin
         cfg_next = local_cfg;
      end else if (remote_wr && remote_allowed) begin
         if (remote_byte[`PP_U_BIT]) begin
            cfg_next.enabled = 1'b0;
         end else begin
            cfg_next.enabled = 1'b1;
            cfg_next.sense   = remote_byte[`PP_S_BIT];
            cfg_next.line    = remote_byte[2:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_reg <= '0;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // Drive assigned line only when ist matches sense
   always_comb begin
      resp = 8'h00;
      if (cfg_reg.enabled && (ist == cfg_reg.sense)) begin
         resp[cfg_reg.line] = 1'b1;
      end
   end

   assign cfg = cfg_reg;
endmodule : pp_response

// *** sim/pp_engine_properties.sv ***
// Concurrent checks on the parallel-poll engine ports
`timescale 1ns/1ps
module pp_engine_properties
   import pp_pkg::*;
(
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       req_valid,
   input wire req_t       req,
   input wire logic       req_ready,
   input wire logic       done,
   input wire logic       capability_error,
   input wire logic       not_controller_error,
   input wire logic       local_option,
   input wire logic       controller_in_charge,
   input wire logic       bus_host_mode,
   input wire logic       srq_out,
   input wire logic       ist_out,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic       cmd_ready,
   input wire logic       poll_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic take;
   logic lcl;
   op_t  op_reg;
   op_t  op_next;
   // Request acceptance and kind of request in flight
   assign take = req_valid && req_ready;
   assign lcl = req.op != OP_POLL && !req.no_addr && req.addr == 8'hFF;
   always_comb op_next = take ? req.op : op_reg;
   always_ff @(posedge clk) op_reg <= op_next;

   property p_done_pulse; done |=> !done; endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done held beyond one cycle");
   property p_cmd_hold;
      cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold)
      else $error("command byte dropped before accept");
   property p_enable;
      cmd_valid && cmd_ready && cmd_byte == 8'h05
         && op_reg == OP_CONFIGURE |=> cmd_valid && cmd_byte[7:4] == 4'h6;
   endproperty
   a_enable: assert property (p_enable)
      else $error("enable byte missing or U bit set");
   property p_disable;
      cmd_valid && cmd_ready && cmd_byte == 8'h05
         && op_reg == OP_UNCONFIGURE |=> cmd_valid && cmd_byte == 8'h70;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable byte missing after configure command");
   property p_ppu;
      take && req.op == OP_UNCONFIGURE && req.no_addr && controller_in_charge
         |=> cmd_valid && cmd_byte == 8'h15;
   endproperty
   a_ppu: assert property (p_ppu)
      else $error("universal unconfigure not sent");
   property p_no_cic;
      take && !lcl && !controller_in_charge
         |=> !cmd_valid throughout (##[0:3] not_controller_error);
   endproperty
   a_no_cic: assert property (p_no_cic)
      else $error("bus work without controller role");
   property p_cap;
      take && lcl && !local_option
         |=> !cmd_valid throughout (##[0:3] capability_error);
   endproperty
   a_cap: assert property (p_cap)
      else $error("local request without option not refused");
   property p_poll; $rose(poll_active) |=> poll_active ##1 !poll_active;
   endproperty
   a_poll: assert property (p_poll)
      else $error("poll phase length wrong");
   property p_ist;
      bus_host_mode && $past(bus_host_mode) && $stable(srq_out)
         |-> ist_out == srq_out;
   endproperty
   a_ist: assert property (p_ist)
      else $error("status bit does not follow service request");
endmodule : pp_engine_properties

bind pp_engine pp_engine_properties pp_engine_properties_inst (
   .clk                  (clk),
   .resetn               (resetn),
   .req_valid            (req_valid),
   .req                  (req),
   .req_ready            (req_ready),
   .done                 (done),
   .capability_error     (capability_error),
   .not_controller_error (not_controller_error),
   .local_option         (local_option),
   .controller_in_charge (controller_in_charge),
   .bus_host_mode        (bus_host_mode),
   .srq_out              (srq_out),
   .ist_out              (ist_out),
   .cmd_valid            (cmd_valid),
   .cmd_byte             (cmd_byte),
   .cmd_ready            (cmd_ready),
   .poll_active          (poll_active)
);

// *** sim/pp_engine_tb_top.sv ***
// Self-checking bench for the parallel-poll engine
`timescale 1ns/1ps
module pp_engine_tb_top
   import pp_pkg::*;
;
   logic        clk, resetn, req_valid, req_ready, done, stall;
   logic        capability_error, not_controller_error, local_option;
   logic        bus_host_mode, controller_in_charge, srq_out, ist_out;
   logic        service_request_enable_function, cmd_valid, cmd_ready;
   logic        poll_active, dio_oe, rx_cmd_valid, device_ist;
   logic [7:0]  poll_result, cmd_byte, dio_in, dio_out, rx_cmd_byte;
   logic [7:0]  ist, dev_dio;
   logic [11:0] q [$];
   logic [31:0] seed = 32'hAB317AD1;
   req_t        req;
   int          errors, checks;
   int          cyc = 0;

   pp_engine pp_engine_inst (
      .clk                             (clk),
      .resetn                          (resetn),
      .req_valid                       (req_valid),
      .req                             (req),
      .req_ready                       (req_ready),
      .done                            (done),
      .poll_result                     (poll_result),
      .capability_error                (capability_error),
      .not_controller_error            (not_controller_error),
      .local_option                    (local_option),
      .bus_host_mode                   (bus_host_mode),
      .controller_in_charge            (controller_in_charge),
      .service_request_enable_function (service_request_enable_function),
      .srq_out                         (srq_out),
      .cmd_valid                       (cmd_valid),
      .cmd_byte                        (cmd_byte),
      .cmd_ready                       (cmd_ready),
      .poll_active                     (poll_active),
      .dio_in                          (dio_in),
      .dio_out                         (dio_out),
      .dio_oe                          (dio_oe),
      .rx_cmd_valid                    (rx_cmd_valid),
      .rx_cmd_byte                     (rx_cmd_byte),
      .device_ist                      (device_ist),
      .ist_out                         (ist_out)
   );
   pp_instruments pp_instruments_inst (
      .clk         (clk),
      .resetn      (resetn),
      .stall       (stall),
      .cmd_valid   (cmd_valid),
      .cmd_byte    (cmd_byte),
      .cmd_ready   (cmd_ready),
      .poll_active (poll_active),
      .ist         (ist),
      .dev_dio     (dev_dio)
   );
   // Wired-OR of instrument lines and own response
   assign dio_in = dev_dio | (dio_oe ? dio_out : 8'h00);
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic report_and_stop();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic cmp(logic [11:0] got, logic [11:0] m);
      logic [11:0] e;
      e = q.size() ? q.pop_front() : 12'hFFF;
      checks++;
      if ((got & m) !== (e & m)) begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e & m, got & m);
      end
   endtask : cmp
   // Random stall and hang guard
   always @(posedge clk) begin
      seed = xs(seed);
      stall <= seed[0] & seed[1];
      cyc++;
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   // Oldest note against each command byte and each completion
   always @(posedge clk) if (resetn) begin
      if (cmd_valid && cmd_ready) cmp({4'h0, cmd_byte}, 12'hFFF);
      if (done) cmp({q[0][11:10] == 2'd1 ? 2'd1 : 2'd2, capability_error,
         not_controller_error, poll_result},
         q[0][11:10] == 2'd1 ? 12'hFFF : 12'hF00);
   end
   task automatic rq(op_t o, logic [7:0] a, logic [3:0] l, logic s,
                     logic n, logic [11:0] dn);
      q.push_back(dn);
      @(posedge clk);
      req <= '{o, a, l[2:0], s, n};
      req_valid <= 1;
      do @(posedge clk); while (req_ready !== 1'b1);
      req_valid <= 0;
      do @(posedge clk); while (done !== 1'b1);
   endtask : rq
   task automatic sq(op_t o, logic [7:0] a, logic [3:0] l, logic s,
                     logic [7:0] last);
      q.push_back(12'h040);
      q.push_back(12'h03F);
      q.push_back(12'h020 + a);
      q.push_back(12'h005);
      q.push_back({4'h0, last});
      rq(o, a, l, s, 0, 12'h800);
   endtask : sq
   task automatic pl(logic [11:0] e);
      rq(OP_POLL, seed[7:0], seed[11:8], seed[12], seed[13], 12'h400 | e);
   endtask : pl
   task automatic rx(logic [7:0] b);
      @(posedge clk);
      rx_cmd_byte <= b;
      rx_cmd_valid <= 1;
      @(posedge clk);
      rx_cmd_valid <= 0;
   endtask : rx
   // Main sequence
   initial begin
      {resetn, req_valid, local_option, bus_host_mode, rx_cmd_valid} = 0;
      {service_request_enable_function, device_ist, stall} = 0;
      {req, rx_cmd_byte, ist, errors, checks} = 0;
      controller_in_charge = 1;
      repeat (8) @(posedge clk);
      resetn <= 1;
      sq(OP_CONFIGURE, 8'h06, 4, 0, 8'h63);
      for (int i = 1; i < 4; i++) sq(OP_CONFIGURE, 8'(i), 5, 1, 8'h6C);
      sq(OP_CONFIGURE, 8'h05, 3, 1, 8'h6A);
      ist <= 8'h22;
      pl(8'h1C);
      ist <= 8'h48;
      pl(8'h10);
      for (int l = 1; l < 9; l++)
         for (int s = 0; s < 2; s++)
            sq(OP_CONFIGURE, 8'h07, 4'(l), 1'(s),
               {4'h6, 1'(s), 3'(l - 1)});
      sq(OP_UNCONFIGURE, 8'h02, 0, 0, 8'h70);
      ist <= 8'h04;
      pl(8'h08);
      q.push_back(12'h015);
      rq(OP_UNCONFIGURE, 8'h00, 0, 0, 1, 12'h800);
      ist <= 8'h00;
      pl(8'h00);
      rq(OP_CONFIGURE, 8'hFF, 5, 0, 0, 12'hA00);
      pl(8'h00);
      local_option <= 1;
      rq(OP_CONFIGURE, 8'hFF, 5, 0, 0, 12'h800);
      pl(8'h10);
      device_ist <= 1;
      rx(8'h6F);
      pl(8'h00);
      device_ist <= 0;
      pl(8'h10);
      rq(OP_UNCONFIGURE, 8'hFF, 0, 0, 0, 12'h800);
      pl(8'h00);
      local_option <= 0;
      rx(8'h6D);
      device_ist <= 1;
      pl(8'h20);
      rx(8'h7A);
      pl(8'h00);
      controller_in_charge <= 0;
      rq(OP_POLL, 8'h00, 0, 0, 0, 12'h900);
      rq(OP_CONFIGURE, 8'h04, 1, 0, 0, 12'h900);
      bus_host_mode <= 1;
      local_option <= 1;
      device_ist <= seed[3];
      rq(OP_CONFIGURE, 8'hFF, 2, 1, 0, 12'hA00);
      service_request_enable_function <= 1;
      repeat (6) @(posedge clk);
      q.push_back(12'h003);
      cmp({10'h000, srq_out, ist_out}, 12'hFFF);
      service_request_enable_function <= 0;
      repeat (6) @(posedge clk);
      q.push_back(12'h000);
      cmp({10'h000, srq_out, ist_out}, 12'hFFF);
      report_and_stop();
   end
endmodule : pp_engine_tb_top

// *** sim/pp_instruments.sv ***
// Behavioural model of the instruments on the bus
`timescale 1ns/1ps
module pp_instruments (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       stall,
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_byte,
   output logic            cmd_ready,
   input  wire logic       poll_active,
   input  wire logic [7:0] ist,
   output logic [7:0]      dev_dio
);
   logic [7:0] lis, en, sn;
   logic [2:0] ln [8];
   logic       ppc;
   // Accept bytes unless the bus side stalls
   assign cmd_ready = !stall;
   // Decode addressing and poll configuration
   always @(posedge clk) begin
      if (!resetn) begin
         lis <= 8'h00;
         en <= 8'h00;
         ppc <= 1'b0;
      end else if (cmd_valid && cmd_ready) begin
         ppc <= cmd_byte == 8'h05;
         if (cmd_byte == 8'h3F) lis <= 8'h00;
         if (cmd_byte[7:3] == 5'b00100) lis[cmd_byte[2:0]] <= 1'b1;
         if (cmd_byte == 8'h15) en <= 8'h00;
         for (int i = 0; i < 8; i++)
            if (ppc && lis[i] && cmd_byte[7:5] == 3'b011) begin
               en[i] <= !cmd_byte[4];
               sn[i] <= cmd_byte[3];
               ln[i] <= cmd_byte[2:0];
            end
      end
   end
   // Wired-OR response during a poll
   always_comb begin
      dev_dio = 8'h00;
      for (int i = 0; i < 8; i++)
         if (poll_active && en[i] && ist[i] == sn[i])
            dev_dio[ln[i]] = 1'b1;
   end
endmodule : pp_instruments
